// ==== sdram_cmd_pkg.sv ====
// package for the four-bank sdram command state logic
// assumes both ends run on one 200 mhz clock, 5 ns period
`default_nettype none
package sdram_cmd_pkg;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int NUM_BANKS = 4;
    localparam int BANK_W = 2;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 12;
    localparam int AUTO_PRE_BIT = 10;
    // times in ns, as printed defaults of our own choosing
    localparam int MODE_SET_DELAY_NS = 10;
    localparam int PRECHARGE_TIME_NS = 18;
    localparam int ACTIVATE_TO_COLUMN_DELAY_NS = 18;
    localparam int WRITE_RECOVERY_TIME_NS = 12;
    localparam int READ_LATENCY = 3;
    localparam int BURST_LEN = 4;
    // least times round up to whole cycles
    localparam int MODE_SET_CYC = (MODE_SET_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PRECHARGE_CYC = (PRECHARGE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ACTIVATE_CYC =
        (ACTIVATE_TO_COLUMN_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WRITE_RECOVERY_CYC =
        (WRITE_RECOVERY_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 4;

    // decoded command; codes are {cs_n, ras_n, cas_n, we_n}
    typedef enum logic [3:0] {
        CMD_INHIBIT = 4'h8,
        CMD_NOP = 4'h7,
        CMD_ACTIVATE = 4'h3,
        CMD_READ = 4'h5,
        CMD_WRITE = 4'h4,
        CMD_PRECHARGE = 4'h2,
        CMD_REFRESH = 4'h1,
        CMD_MODE_LOAD = 4'h0,
        CMD_BURST_STOP = 4'h6
    } cmd_t;

    typedef enum logic [3:0] {
        BANK_IDLE,
        BANK_ACTIVATING,
        BANK_ACTIVE,
        BANK_READ,
        BANK_WRITE,
        BANK_READ_AP,
        BANK_WRITE_AP,
        BANK_RECOVER,
        BANK_PRECHARGING
    } bank_state_t;

    // map the four strobe levels to a command
    function automatic cmd_t decode_cmd(input logic cs_n, input logic ras_n,
                                        input logic cas_n, input logic we_n);
        if (cs_n) begin
            return CMD_INHIBIT;
        end
        return cmd_t'({1'b0, ras_n, cas_n, we_n});
    endfunction
endpackage
`default_nettype wire

// ==== sdram_cmd_if.sv ====
// interface joining the memory controller to the sdram command logic
// assumes one shared clock; dq is split into input, output and enable
`timescale 1ns/1ps
`default_nettype none
interface sdram_cmd_if;
    import sdram_cmd_pkg::*;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [1:0] dqm;
    logic [DATA_W-1:0] ctl_dq;
    logic ctl_dq_oe_n;
    logic [DATA_W-1:0] mem_dq;
    logic mem_dq_oe_n;
    modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, ctl_dq, ctl_dq_oe_n,
                 input mem_dq, mem_dq_oe_n);
    modport mem (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, ctl_dq, ctl_dq_oe_n,
                 output mem_dq, mem_dq_oe_n);
endinterface
`default_nettype wire

// ==== bank_tracker.sv ====
// one bank's state tracker with its timing counter
// assumes the parent decodes commands and cross-bank interrupts
`timescale 1ns/1ps
`default_nettype none
module bank_tracker (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_activate,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic i_auto_pre,
    input wire logic i_precharge,
    input wire logic i_burst_end,
    input wire logic i_cut_read,
    input wire logic i_cut_write,
    input wire logic i_mode_hold,
    output logic [3:0] o_state
);
    import sdram_cmd_pkg::*;
    bank_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;

    ////////////////////////////////////////////////////////////////
    // next state; no command leaves state and counter to run on
    always_comb begin
        state_d = state_q;
        cnt_d = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
        unique case (state_q)
            BANK_IDLE: begin
                if (i_activate) begin
                    state_d = BANK_ACTIVATING;
                    cnt_d = CNT_W'(ACTIVATE_CYC - 1);
                end
            end
            BANK_ACTIVATING, BANK_PRECHARGING: begin
                if (cnt_q == '0) begin
                    state_d = (state_q == BANK_ACTIVATING) ? BANK_ACTIVE : BANK_IDLE;
                end
            end
            BANK_ACTIVE, BANK_READ, BANK_WRITE: begin
                if (i_read || i_write) begin
                    state_d = i_auto_pre ? (i_read ? BANK_READ_AP : BANK_WRITE_AP)
                                         : (i_read ? BANK_READ : BANK_WRITE);
                end else if (i_precharge) begin
                    state_d = BANK_PRECHARGING;
                    cnt_d = CNT_W'(PRECHARGE_CYC - 1);
                end else if (i_burst_end || i_cut_read || i_cut_write) begin
                    state_d = BANK_ACTIVE;
                end
            end
            BANK_READ_AP: begin
                if (i_burst_end || i_cut_read || i_cut_write) begin
                    state_d = BANK_PRECHARGING;
                    cnt_d = CNT_W'(PRECHARGE_CYC - 1);
                end
            end
            BANK_WRITE_AP: begin
                if (i_burst_end || i_cut_read || i_cut_write) begin
                    state_d = BANK_RECOVER;
                    cnt_d = CNT_W'(WRITE_RECOVERY_CYC - 1);
                end
            end
            BANK_RECOVER: begin
                if (cnt_q == '0) begin
                    state_d = BANK_PRECHARGING;
                    cnt_d = CNT_W'(PRECHARGE_CYC - 1);
                end
            end
        endcase
        if (i_precharge && state_q != BANK_READ_AP
            && state_q != BANK_WRITE_AP && state_q != BANK_RECOVER) begin
            state_d = BANK_PRECHARGING;
            cnt_d = CNT_W'(PRECHARGE_CYC - 1);
        end
        if (i_mode_hold) begin
            state_d = BANK_IDLE;
        end
    end

    // register state
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_q <= BANK_IDLE;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    assign o_state = state_q;
endmodule
`default_nettype wire

// ==== sdram_cmd_mem.sv ====
// memory end: four bank trackers, burst ownership and data path
// assumes commands arrive synchronous to i_clk from a legal controller
`timescale 1ns/1ps
`default_nettype none
module sdram_cmd_mem #(
    parameter int READ_LAT = sdram_cmd_pkg::READ_LATENCY,
    parameter int BURST = sdram_cmd_pkg::BURST_LEN
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    sdram_cmd_if.mem bus,
    output logic [4*sdram_cmd_pkg::NUM_BANKS-1:0] o_bank_states,
    output logic o_mode_busy,
    output logic o_wr_valid,
    output logic [sdram_cmd_pkg::BANK_W-1:0] o_wr_bank,
    output logic [sdram_cmd_pkg::DATA_W-1:0] o_wr_data,
    input wire logic [sdram_cmd_pkg::DATA_W-1:0] i_rd_data
);
    import sdram_cmd_pkg::*;
    cmd_t cmd;
    logic live;
    logic [NUM_BANKS-1:0] act, rd, wr, pre;
    logic [NUM_BANKS-1:0] end_b, cut_rd, cut_wr;
    logic [3:0] st [NUM_BANKS];

    ////////////////////////////////////////////////////////////////
    // command decode, ignored unless clock enable stays high and no mode-access hold runs
    assign cmd = decode_cmd(bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n);
    logic cke_q;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cke_q <= 1'b0;
        end else begin
            cke_q <= bus.cke;
        end
    end
    assign live = cke_q && bus.cke && !o_mode_busy;

    ////////////////////////////////////////////////////////////////
    // burst owner: latest read or write, with remaining beats
    logic burst_q, burst_d, burst_wr_q, burst_wr_d;
    logic [BANK_W-1:0] owner_q, owner_d;
    logic [7:0] beats_q, beats_d;
    logic new_burst, stop;
    assign new_burst = live && (cmd == CMD_READ || cmd == CMD_WRITE);
    assign stop = live && cmd == CMD_BURST_STOP;
    always_comb begin
        burst_d = burst_q;
        burst_wr_d = burst_wr_q;
        owner_d = owner_q;
        beats_d = beats_q;
        if (new_burst) begin
            burst_d = 1'b1;
            burst_wr_d = (cmd == CMD_WRITE);
            owner_d = bus.ba;
            beats_d = 8'(BURST - 1);
        end else if (stop || (burst_q && beats_q == 8'h00)) begin
            burst_d = 1'b0;
        end else if (burst_q) begin
            beats_d = beats_q - 8'h01;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            burst_q <= 1'b0;
            burst_wr_q <= 1'b0;
            owner_q <= '0;
            beats_q <= '0;
        end else begin
            burst_q <= burst_d;
            burst_wr_q <= burst_wr_d;
            owner_q <= owner_d;
            beats_q <= beats_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // per-bank strobes and the trackers
    logic all_pre, mode_load;
    assign all_pre = live && cmd == CMD_PRECHARGE && bus.addr[AUTO_PRE_BIT];
    assign mode_load = live && cmd == CMD_MODE_LOAD;
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        logic mine;
        logic owns;
        assign mine = bus.ba == BANK_W'(b);
        assign owns = burst_q && owner_q == BANK_W'(b);
        assign act[b] = live && cmd == CMD_ACTIVATE && mine;
        assign rd[b] = live && cmd == CMD_READ && mine;
        assign wr[b] = live && cmd == CMD_WRITE && mine;
        // precharge-all restarts idle banks too; a single precharge leaves them alone
        assign pre[b] = all_pre
            || (live && cmd == CMD_PRECHARGE && mine && st[b] != BANK_IDLE);
        assign end_b[b] = owns && (stop || beats_q == 8'h00);
        assign cut_rd[b] = owns && !mine && live && cmd == CMD_READ;
        assign cut_wr[b] = owns && !mine && live && cmd == CMD_WRITE;
        bank_tracker u_trk (
            .i_clk(i_clk),
            .i_sys_rst(i_sys_rst),
            .i_activate(act[b]),
            .i_read(rd[b]),
            .i_write(wr[b]),
            .i_auto_pre(bus.addr[AUTO_PRE_BIT]),
            .i_precharge(pre[b]),
            .i_burst_end(end_b[b]),
            .i_cut_read(cut_rd[b]),
            .i_cut_write(cut_wr[b]),
            .i_mode_hold(mode_load),
            .o_state(st[b])
        );
        assign o_bank_states[4*b +: 4] = st[b];
    end

    ////////////////////////////////////////////////////////////////
    // mode-access hold
    logic [CNT_W-1:0] mode_cnt_q, mode_cnt_d;
    always_comb begin
        mode_cnt_d = mode_cnt_q;
        if (mode_load) begin
            mode_cnt_d = CNT_W'(MODE_SET_CYC);
        end else if (mode_cnt_q != '0) begin
            mode_cnt_d = mode_cnt_q - 1'b1;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            mode_cnt_q <= '0;
        end else begin
            mode_cnt_q <= mode_cnt_d;
        end
    end
    assign o_mode_busy = mode_cnt_q != '0;

    ////////////////////////////////////////////////////////////////
    // read data pipe: newest read owns dq one read latency later
    logic [READ_LAT-1:0] rd_pipe_q, rd_pipe_d;
    logic [DATA_W-1:0] dq_q, dq_d;
    logic oe_n_q, oe_n_d;
    logic rd_beat;
    // beats 3..1 carry words after the command's own; beat 0 only closes the burst
    assign rd_beat = burst_q && !burst_wr_q && beats_q != 8'h00 && !stop;
    always_comb begin
        rd_pipe_d = {rd_pipe_q[READ_LAT-2:0], (live && cmd == CMD_READ) || rd_beat};
        if (live && cmd == CMD_WRITE) begin
            rd_pipe_d = '0;
        end
        oe_n_d = !(rd_pipe_q[READ_LAT-2] && !(live && cmd == CMD_WRITE));
        dq_d = i_rd_data;
    end
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rd_pipe_q <= '0;
            dq_q <= '0;
            oe_n_q <= 1'b1;
        end else begin
            rd_pipe_q <= rd_pipe_d;
            dq_q <= dq_d;
            oe_n_q <= oe_n_d;
        end
    end
    assign bus.mem_dq = dq_q;
    assign bus.mem_dq_oe_n = oe_n_q;

    ////////////////////////////////////////////////////////////////
    // write capture: data taken with the command and each burst beat
    logic wv_q, wv_d;
    logic [BANK_W-1:0] wb_q, wb_d;
    logic [DATA_W-1:0] wd_q, wd_d;
    always_comb begin
        wv_d = (live && cmd == CMD_WRITE)
            || (burst_q && burst_wr_q && beats_q != 8'h00 && !new_burst && !stop);
        wb_d = (live && cmd == CMD_WRITE) ? bus.ba : owner_q;
        wd_d = bus.ctl_dq;
    end
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            wv_q <= 1'b0;
            wb_q <= '0;
            wd_q <= '0;
        end else begin
            wv_q <= wv_d;
            wb_q <= wb_d;
            wd_q <= wd_d;
        end
    end
    assign o_wr_valid = wv_q;
    assign o_wr_bank = wb_q;
    assign o_wr_data = wd_q;
endmodule
`default_nettype wire

// ==== sdram_cmd_ctl.sv ====
// controller end: issues one user command a cycle onto the strobes
// assumes the user keeps the legal command order itself
`timescale 1ns/1ps
`default_nettype none
module sdram_cmd_ctl (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    sdram_cmd_if.ctl bus,
    input wire logic i_valid,
    input wire sdram_cmd_pkg::cmd_t i_cmd,
    input wire logic [sdram_cmd_pkg::BANK_W-1:0] i_bank,
    input wire logic [sdram_cmd_pkg::ADDR_W-1:0] i_addr,
    input wire logic [sdram_cmd_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_mask,
    output logic o_ready,
    output logic o_rd_valid,
    output logic [sdram_cmd_pkg::DATA_W-1:0] o_rd_data
);
    import sdram_cmd_pkg::*;
    logic [3:0] code_q, code_d;
    logic [BANK_W-1:0] ba_q, ba_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wd_q, wd_d;
    logic mask_q, mask_d, drive_q, drive_d;
    logic [CNT_W-1:0] hold_q, hold_d;
    logic rv_q;
    logic [DATA_W-1:0] rdat_q;

    ////////////////////////////////////////////////////////////////
    // command launch; nop while waiting out mode set delay
    assign o_ready = hold_q == '0;
    always_comb begin
        code_d = CMD_NOP;
        ba_d = ba_q;
        addr_d = addr_q;
        wd_d = i_wdata;
        mask_d = i_mask;
        drive_d = 1'b0;
        hold_d = (hold_q != '0) ? hold_q - 1'b1 : hold_q;
        if (i_valid && o_ready) begin
            code_d = i_cmd;
            ba_d = i_bank;
            addr_d = i_addr;
            drive_d = (i_cmd == CMD_WRITE);
            if (i_cmd == CMD_MODE_LOAD) begin
                hold_d = CNT_W'(MODE_SET_CYC);
            end
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            code_q <= CMD_INHIBIT;
            ba_q <= '0;
            addr_q <= '0;
            wd_q <= '0;
            mask_q <= 1'b0;
            drive_q <= 1'b0;
            hold_q <= '0;
            rv_q <= 1'b0;
            rdat_q <= '0;
        end else begin
            code_q <= code_d;
            ba_q <= ba_d;
            addr_q <= addr_d;
            wd_q <= wd_d;
            mask_q <= mask_d;
            drive_q <= drive_d;
            hold_q <= hold_d;
            rv_q <= !bus.mem_dq_oe_n;
            rdat_q <= bus.mem_dq;
        end
    end

    // pins; clock enable held high for the cross-bank rules
    assign bus.cke = !i_sys_rst;
    assign {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} =
        (code_q == CMD_INHIBIT) ? 4'h8 : {1'b0, code_q[2:0]};
    assign bus.ba = ba_q;
    assign bus.addr = addr_q;
    assign bus.dqm = {2{mask_q}};
    assign bus.ctl_dq = wd_q;
    assign bus.ctl_dq_oe_n = !drive_q;
    assign o_rd_valid = rv_q;
    assign o_rd_data = rdat_q;
endmodule
`default_nettype wire

// ==== sdram_cmd_chk.sv ====
// checker for the command link between the controller and memory ends
// assumes it sits beside the interface and sees its signals directly
`timescale 1ns/1ps
`default_nettype none
module sdram_cmd_chk (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [sdram_cmd_pkg::BANK_W-1:0] ba,
    input wire logic [sdram_cmd_pkg::ADDR_W-1:0] addr,
    input wire logic [1:0] dqm,
    input wire logic [sdram_cmd_pkg::DATA_W-1:0] ctl_dq,
    input wire logic ctl_dq_oe_n,
    input wire logic [sdram_cmd_pkg::DATA_W-1:0] mem_dq,
    input wire logic mem_dq_oe_n
);
    import sdram_cmd_pkg::*;
    logic rd;
    logic wr;
    logic ml;
    logic bst;
    logic quiet;
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    ////////////////////////////////////////////////////////////////////////////////
    // decoded strobe patterns on the wire
    assign rd = !cs_n && ras_n && !cas_n && we_n;
    assign wr = !cs_n && ras_n && !cas_n && !we_n;
    assign ml = !cs_n && !ras_n && !cas_n && !we_n;
    assign bst = !cs_n && ras_n && cas_n && !we_n;
    assign quiet = cs_n || (ras_n && cas_n && we_n);
    // cycles since the latest read, saturating at 7
    always_comb begin
        cnt_d = (cnt_q == 3'h7) ? cnt_q : cnt_q + 3'h1;
        if (rd && cke) begin
            cnt_d = 3'h0;
        end
    end
    always_ff @(posedge i_clk) begin
        cnt_q <= i_sys_rst ? 3'h7 : cnt_d;
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    property p_rst_quiet;
        $fell(i_sys_rst) |-> cs_n && ctl_dq_oe_n && mem_dq_oe_n;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("link busy out of reset");
    property p_cke_up;
        $fell(i_sys_rst) |-> ##[0:2] cke;
    endproperty
    a_cke_up: assert property (p_cke_up) else $error("clock enable stays low");
    property p_mode_hold;
        ml && cke |=> quiet [*2];
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("command in mode hold");
    property p_read_lat;
        rd && cke && $past(cke) |-> ##3 !mem_dq_oe_n;
    endproperty
    a_read_lat: assert property (p_read_lat) else $error("read data late");
    property p_read_end;
        !mem_dq_oe_n |-> cnt_q <= 3'h5;
    endproperty
    a_read_end: assert property (p_read_end) else $error("read data overruns");
    property p_wr_drive;
        wr |-> !ctl_dq_oe_n;
    endproperty
    a_wr_drive: assert property (p_wr_drive) else $error("write word not driven");
    property p_wr_cut;
        wr && cke && $past(cke) |=> mem_dq_oe_n;
    endproperty
    a_wr_cut: assert property (p_wr_cut) else $error("read not cut by write");
    property p_stop;
        bst && cke && $past(cke) |-> ##[1:4] mem_dq_oe_n;
    endproperty
    a_stop: assert property (p_stop) else $error("burst not stopped");
endmodule
`default_nettype wire

// ==== sdram_multibank_command_control_tb_top.sv ====
// testbench joining the controller and memory ends across the link
// assumes the package, interface, both ends and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module sdram_multibank_command_control_tb_top;
    import sdram_cmd_pkg::*;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_valid = 1'b0;
    cmd_t i_cmd = CMD_NOP;
    logic [BANK_W-1:0] i_bank = 2'h0;
    logic [ADDR_W-1:0] i_addr = 12'h000;
    logic [DATA_W-1:0] i_wdata = 16'h0000;
    logic i_mask = 1'b0;
    logic [DATA_W-1:0] i_rd_data = 16'h0000;
    logic o_ready, o_rd_valid, o_mode_busy, o_wr_valid;
    logic [DATA_W-1:0] o_rd_data, o_wr_data;
    logic [BANK_W-1:0] o_wr_bank;
    logic [4*NUM_BANKS-1:0] o_bank_states;
    logic [BANK_W+DATA_W-1:0] wq[$];
    logic [DATA_W-1:0] rq[$];
    int fails = 0;
    int n_compared = 0;
    sdram_cmd_if bus_if();
    sdram_cmd_ctl i_sdram_cmd_ctl (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .bus(bus_if),
        .i_valid(i_valid), .i_cmd(i_cmd), .i_bank(i_bank), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_mask(i_mask), .o_ready(o_ready),
        .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data));
    sdram_cmd_mem i_sdram_cmd_mem (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .bus(bus_if),
        .o_bank_states(o_bank_states), .o_mode_busy(o_mode_busy),
        .o_wr_valid(o_wr_valid), .o_wr_bank(o_wr_bank), .o_wr_data(o_wr_data),
        .i_rd_data(i_rd_data));
    sdram_cmd_chk i_sdram_cmd_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .cke(bus_if.cke),
        .cs_n(bus_if.cs_n), .ras_n(bus_if.ras_n), .cas_n(bus_if.cas_n), .we_n(bus_if.we_n),
        .ba(bus_if.ba), .addr(bus_if.addr), .dqm(bus_if.dqm), .ctl_dq(bus_if.ctl_dq),
        .ctl_dq_oe_n(bus_if.ctl_dq_oe_n), .mem_dq(bus_if.mem_dq),
        .mem_dq_oe_n(bus_if.mem_dq_oe_n));
    ////////////////////////////////////////////////////////////////////////////////
    // clock at 5 ns
    always #2.5 i_clk = ~i_clk;
    // one comparison, counted
    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            fails++;
            $display("Error %0t: %s", $time, msg);
        end
    endtask
    task automatic end_of_test();
        chk(wq.size() == 0 && rq.size() == 0, "results missing");
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // one user command, taken at the next edge
    task automatic issue(input cmd_t c, input logic [BANK_W-1:0] b,
                         input logic [ADDR_W-1:0] a);
        i_valid <= 1'b1;
        i_cmd <= c;
        i_bank <= b;
        i_addr <= a;
        @(posedge i_clk);
    endtask
    task automatic pause(input int n);
        i_valid <= 1'b0;
        repeat (n) @(posedge i_clk);
    endtask
    // write of n words; each word is noted as expected at the memory
    task automatic wr(input logic [BANK_W-1:0] b, input logic ap, input int n);
        logic [DATA_W-1:0] d;
        for (int k = 0; k < n; k++) begin
            d = DATA_W'($urandom);
            i_wdata <= d;
            wq.push_back({b, d});
            if (k == 0) begin
                issue(CMD_WRITE, b, {1'b0, ap, 10'h000});
            end else begin
                pause(1);
            end
        end
    endtask
    // read expecting n beats of the held array value
    task automatic rd(input logic [BANK_W-1:0] b, input logic ap, input int n);
        repeat (n) rq.push_back(i_rd_data);
        issue(CMD_READ, b, {1'b0, ap, 10'h000});
    endtask
    task automatic st(input int b, input bank_state_t s);
        chk(o_bank_states[4*b +: 4] === s, "bank state");
    endtask
    task automatic all_st(input bank_state_t s);
        for (int b = 0; b < NUM_BANKS; b++) begin
            st(b, s);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // results at the ports are matched against the oldest note
    always @(posedge i_clk) begin
        if (o_wr_valid === 1'b1) begin
            chk(wq.size() > 0 && {o_wr_bank, o_wr_data} === wq.pop_front(), "write");
        end
        if (o_rd_valid === 1'b1) begin
            chk(rq.size() > 0 && o_rd_data === rq.pop_front(), "read");
        end
    end
    // watchdog over the whole run
    initial begin
        repeat (3000) @(posedge i_clk);
        fails++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(56));
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        i_rd_data <= DATA_W'($urandom);
        pause(4);
        all_st(BANK_IDLE);
        issue(CMD_MODE_LOAD, 2'h0, ADDR_W'($urandom));
        pause(2);
        chk(o_mode_busy === 1'b1 && o_ready === 1'b0, "mode hold");
        pause(4);
        chk(o_mode_busy === 1'b0, "mode end");
        all_st(BANK_IDLE);
        $display("test mode done");
        for (int b = 0; b < NUM_BANKS; b++) begin
            issue(CMD_ACTIVATE, BANK_W'(b), ADDR_W'($urandom));
        end
        issue(CMD_NOP, 2'h0, 12'h000);
        issue(CMD_INHIBIT, 2'h1, 12'h000);
        pause(6);
        all_st(BANK_ACTIVE);
        $display("test activate done");
        wr(2'h0, 1'b0, 2);
        wr(2'h1, 1'b0, 2);
        rd(2'h2, 1'b0, 4);
        issue(CMD_PRECHARGE, 2'h3, 12'h000);
        pause(10);
        st(0, BANK_ACTIVE);
        st(1, BANK_ACTIVE);
        st(3, BANK_IDLE);
        $display("test cut write done");
        rd(2'h0, 1'b1, 2);
        pause(1);
        rd(2'h1, 1'b0, 4);
        pause(2);
        st(0, BANK_PRECHARGING);
        pause(10);
        st(0, BANK_IDLE);
        st(1, BANK_ACTIVE);
        $display("test cut read done");
        issue(CMD_ACTIVATE, 2'h0, ADDR_W'($urandom));
        pause(6);
        wr(2'h0, 1'b1, 4);
        st(0, BANK_WRITE_AP);
        pause(14);
        st(0, BANK_IDLE);
        issue(CMD_ACTIVATE, 2'h0, ADDR_W'($urandom));
        pause(6);
        wr(2'h0, 1'b1, 2);
        wr(2'h2, 1'b0, 4);
        pause(14);
        st(0, BANK_IDLE);
        $display("test auto precharge done");
        rd(2'h1, 1'b0, 1);
        issue(CMD_BURST_STOP, 2'h1, 12'h000);
        issue(CMD_PRECHARGE, 2'h0, 12'h400);
        pause(2);
        all_st(BANK_PRECHARGING);
        pause(6);
        all_st(BANK_IDLE);
        issue(CMD_REFRESH, 2'h0, 12'h000);
        pause(10);
        all_st(BANK_IDLE);
        $display("test precharge all done");
        end_of_test();
    end
endmodule
`default_nettype wire
